/* File: logic/supply_monitor_map.vh */
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// Register byte addresses
`define ADDR_SUPPLY_MON   32'hFFFF0440
`define ADDR_INT_ENABLE   32'hFFFF0444
`define ADDR_ADC_CHANNEL  32'hFFFF0448
`define ADDR_REF_CTRL     32'hFFFF0480

// Supply monitor control fields
`define SM_FLAG_BIT       0
`define SM_ENABLE_BIT     1
`define SM_TRIP_BIT       2
`define SM_STATUS_BIT     3

// Reference control fields
`define REF_1V2_BIT       0
`define REF_2V5_BIT       1
`define REF_BUF_BIT       2
`define REF_RESET         3'h1
`define REF_ALL_OFF       8'h00

// Interrupt enable fields
`define IE_NORMAL_BIT     0
`define IE_FAST_BIT       1

// ADC positive channel select
`define ADC_SEL_W         5
`define ADC_SEL_RESET     5'h00
`define ADC_SEL_SUPPLY    5'h13

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY        1'b0
`define WORD_ZERO         32'h00000000

`endif

/* File: logic/supply_low_flag_unit.v */
`timescale 1ns/10ps

module supply_low_flag_unit (
    input  wire hclk,
    input  wire hresetn,
    input  wire status_high,
    input  wire clear_write,
    output reg  flag_r,
    output reg  holdoff_r,
    output wire request
);

    reg flag_nxt;
    reg holdoff_nxt;

    always @* begin
        flag_nxt    = flag_r;
        holdoff_nxt = holdoff_r;
        if (!status_high) begin
            flag_nxt = 1'b1;
        end else if (clear_write) begin
            flag_nxt = 1'b0;
        end
        if (status_high) begin
            holdoff_nxt = 1'b0;
        end else if (clear_write && flag_r) begin
            holdoff_nxt = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r    <= 1'b0;
            holdoff_r <= 1'b0;
        end else begin
            flag_r    <= flag_nxt;
            holdoff_r <= holdoff_nxt;
        end
    end

    // Level request held until the flag clears or a clear write while low sets the holdoff
    assign request = flag_r & ~holdoff_r;

endmodule // supply_low_flag_unit

/* File: logic/supply_monitor_and_reference_ctrl.v */
`timescale 1ns/10ps
`include "supply_monitor_map.vh"

// Contract
// - Supply-low flag sets whenever the comparator reports supply below trip.
// - Writing one clears the flag while comparator is high; zero does nothing.
// - Flag clear takes effect at once, no timeout, once comparator is high.
// - Handler leaving while low gets no new interrupt until comparator high.
// - Flag interrupts only when enabled as normal or fast interrupt.
// - Bit 3 mirrors comparator, reads one when above trip or disabled.
// - Bit 2 selects trip point: zero is 2.79 V, one is 3.07 V.
// - Bit 1 enables the supply monitor circuit.
// - Monitor control resets to 0x08 whatever the comparator state, as the monitor starts disabled.
// - Reference bit 1 connects internal 2.5 V reference to its pin.
// - Reference bit 0 connects internal 1.2 V reference to its pin.
// - Bit 2 written one drives buffers; only writing 0x00 disables them.
// - Reference control register resets to 0x01.
// - Channel code 10011 routes divided supply to the converter.
module supply_monitor_and_reference_ctrl (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        supply_above_trip,
    output reg         monitor_enable_bit,
    output reg         trip_point_select,
    output reg         vref_2v5_connect,
    output reg         vref_1v2_connect,
    output reg         ref_buffer_enable,
    output reg         adc_route_supply,
    output reg  [4:0]  adc_positive_channel_select,
    output reg         normal_irq_request,
    output reg         fast_irq_request
);

    // Address phase capture
    wire       take;
    reg        wr_pend_r;
    reg        sel_sm_r;
    reg        sel_ie_r;
    reg        sel_adc_r;
    reg        sel_ref_r;

    // Register state
    reg        status_r;
    reg        normal_en_r;
    reg        fast_en_r;
    reg  [2:0] ref_bits_r;
    reg  [`ADC_SEL_W-1:0] adc_sel_r;

    // Next values
    reg        status_nxt;
    reg        normal_en_nxt;
    reg        fast_en_nxt;
    reg  [2:0] ref_bits_nxt;
    reg        ref_buf_nxt;
    reg  [`ADC_SEL_W-1:0] adc_sel_nxt;
    reg        mon_en_nxt;
    reg        trip_nxt;
    reg  [31:0] rdata_nxt;

    wire       sm_write;
    wire       ie_write;
    wire       adc_write;
    wire       ref_write;
    wire       clear_write;
    wire       flag;
    wire       holdoff;
    wire       level_request;

    wire       hit_sm;
    wire       hit_ie;
    wire       hit_adc;
    wire       hit_ref;

    assign take    = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
    assign hit_sm  = (haddr == `ADDR_SUPPLY_MON);
    assign hit_ie  = (haddr == `ADDR_INT_ENABLE);
    assign hit_adc = (haddr == `ADDR_ADC_CHANNEL);
    assign hit_ref = (haddr == `ADDR_REF_CTRL);

    // Data phase write strobes
    assign sm_write  = wr_pend_r & sel_sm_r;
    assign ie_write  = wr_pend_r & sel_ie_r;
    assign adc_write = wr_pend_r & sel_adc_r;
    assign ref_write = wr_pend_r & sel_ref_r;

    // Write one to flag bit; reserved upper bits ignored
    assign clear_write = sm_write & hwdata[`SM_FLAG_BIT];

    supply_low_flag_unit u_flag (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .status_high (status_r),
        .clear_write (clear_write),
        .flag_r      (flag),
        .holdoff_r   (holdoff),
        .request     (level_request)
    );

    // Address phase latch
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            sel_sm_r  <= 1'b0;
            sel_ie_r  <= 1'b0;
            sel_adc_r <= 1'b0;
            sel_ref_r <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= take & hwrite;
            sel_sm_r  <= take & hit_sm;
            sel_ie_r  <= take & hit_ie;
            sel_adc_r <= take & hit_adc;
            sel_ref_r <= take & hit_ref;
        end
    end

    // Control register next values
    always @* begin
        mon_en_nxt    = monitor_enable_bit;
        trip_nxt      = trip_point_select;
        normal_en_nxt = normal_en_r;
        fast_en_nxt   = fast_en_r;
        ref_bits_nxt  = ref_bits_r;
        ref_buf_nxt   = ref_buffer_enable;
        adc_sel_nxt   = adc_sel_r;
        if (sm_write) begin
            mon_en_nxt = hwdata[`SM_ENABLE_BIT];
            trip_nxt   = hwdata[`SM_TRIP_BIT];
        end
        if (ie_write) begin
            normal_en_nxt = hwdata[`IE_NORMAL_BIT];
            fast_en_nxt   = hwdata[`IE_FAST_BIT];
        end
        if (ref_write) begin
            ref_bits_nxt = hwdata[2:0];
            ref_buf_nxt  = (hwdata[7:0] != `REF_ALL_OFF);
        end
        if (adc_write) begin
            adc_sel_nxt = hwdata[`ADC_SEL_W-1:0];
        end
    end

    // Comparator reads high while the monitor is powered down
    always @* begin
        status_nxt = supply_above_trip | ~monitor_enable_bit;
    end

    // Read data prepared in the address phase
    always @* begin
        rdata_nxt = `WORD_ZERO;
        if (take && !hwrite) begin
            if (hit_sm) begin
                rdata_nxt[`SM_FLAG_BIT]   = flag;
                rdata_nxt[`SM_ENABLE_BIT] = monitor_enable_bit;
                rdata_nxt[`SM_TRIP_BIT]   = trip_point_select;
                rdata_nxt[`SM_STATUS_BIT] = status_r;
            end else if (hit_ie) begin
                rdata_nxt[`IE_NORMAL_BIT] = normal_en_r;
                rdata_nxt[`IE_FAST_BIT]   = fast_en_r;
            end else if (hit_adc) begin
                rdata_nxt[`ADC_SEL_W-1:0] = adc_sel_r;
            end else if (hit_ref) begin
                rdata_nxt[2:0] = ref_bits_r;
            end
        end
    end

    // Register state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r           <= 1'b1;
            monitor_enable_bit <= 1'b0;
            trip_point_select  <= 1'b0;
            normal_en_r        <= 1'b0;
            fast_en_r          <= 1'b0;
            ref_bits_r         <= `REF_RESET;
            ref_buffer_enable  <= 1'b0;
            adc_sel_r          <= `ADC_SEL_RESET;
        end else begin
            status_r           <= status_nxt;
            monitor_enable_bit <= mon_en_nxt;
            trip_point_select  <= trip_nxt;
            normal_en_r        <= normal_en_nxt;
            fast_en_r          <= fast_en_nxt;
            ref_bits_r         <= ref_bits_nxt;
            ref_buffer_enable  <= ref_buf_nxt;
            adc_sel_r          <= adc_sel_nxt;
        end
    end

    // Output flops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout                   <= 1'b1;
            hresp                       <= `HRESP_OKAY;
            hrdata                      <= `WORD_ZERO;
            vref_2v5_connect            <= 1'b0;
            vref_1v2_connect            <= 1'b1;
            adc_route_supply            <= 1'b0;
            adc_positive_channel_select <= `ADC_SEL_RESET;
            normal_irq_request          <= 1'b0;
            fast_irq_request            <= 1'b0;
        end else begin
            hreadyout                   <= 1'b1;
            hresp                       <= `HRESP_OKAY;
            hrdata                      <= rdata_nxt;
            vref_2v5_connect            <= ref_bits_nxt[`REF_2V5_BIT];
            vref_1v2_connect            <= ref_bits_nxt[`REF_1V2_BIT];
            adc_route_supply            <= (adc_sel_nxt == `ADC_SEL_SUPPLY);
            adc_positive_channel_select <= adc_sel_nxt;
            normal_irq_request          <= level_request & normal_en_r;
            fast_irq_request            <= level_request & fast_en_r;
        end
    end

endmodule // supply_monitor_and_reference_ctrl

/* File: tb/supply_comparator_model.sv */
`timescale 1ns/10ps

// Comparator output, synchronous to the bus clock
module supply_comparator_model (
    input  wire hclk,
    input  wire supply_ok,
    output reg  supply_above_trip
);
    initial supply_above_trip = 1'b0;
    always @(posedge hclk) begin
        supply_above_trip <= supply_ok;
    end
endmodule // supply_comparator_model

/* File: tb/supply_monitor_sva.sv */
`timescale 1ns/10ps
`include "supply_monitor_map.vh"

module supply_monitor_sva (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        supply_above_trip,
    input wire        monitor_enable_bit,
    input wire        trip_point_select,
    input wire        vref_2v5_connect,
    input wire        vref_1v2_connect,
    input wire        ref_buffer_enable,
    input wire        adc_route_supply,
    input wire [4:0]  adc_positive_channel_select,
    input wire        normal_irq_request,
    input wire        fast_irq_request
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire tk = hsel && htrans[1] && hready;
    reg  rd_mon, rd_unm, wr_mon, wr_ref;
    // Data phase markers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_mon <= 1'b0;
            rd_unm <= 1'b0;
            wr_mon <= 1'b0;
            wr_ref <= 1'b0;
        end else begin
            rd_mon <= tk && !hwrite && haddr == `ADDR_SUPPLY_MON;
            rd_unm <= tk && !hwrite && haddr == 32'hFFFF0450;
            wr_mon <= tk && hwrite && haddr == `ADDR_SUPPLY_MON;
            wr_ref <= tk && hwrite && haddr == `ADDR_REF_CTRL;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_status_read: assert property (rd_mon |-> hrdata[31:4] == 28'h0 &&
        hrdata[3] == $past(supply_above_trip | !monitor_enable_bit, 2)) else $error("status bad");
    a_unmapped_zero: assert property (rd_unm |-> hrdata == 32'h0) else $error("unmapped read");
    a_route_code: assert property (adc_route_supply ==
        (adc_positive_channel_select == 5'h13)) else $error("channel route mismatch");
    a_buf_off_zero: assert property ($fell(ref_buffer_enable) |->
        $past(wr_ref && hwdata[7:0] == 8'h00)) else $error("buffer off without zero write");
    a_ref_pins: assert property ($changed({vref_2v5_connect, vref_1v2_connect}) |->
        $past(wr_ref) && {vref_2v5_connect, vref_1v2_connect} == $past(hwdata[1:0]))
        else $error("reference pin change");
    a_mon_pins: assert property ($changed({trip_point_select, monitor_enable_bit}) |->
        $past(wr_mon) && {trip_point_select, monitor_enable_bit} == $past(hwdata[2:1]))
        else $error("monitor control change");
    a_clear_irq: assert property (wr_mon && hwdata[0] &&
        $past(supply_above_trip | !monitor_enable_bit) |-> ##2
        !normal_irq_request && !fast_irq_request) else $error("irq after clear");
    c_low_read: cover property (rd_mon && !hrdata[3]);
    c_irq: cover property ($rose(normal_irq_request));
    c_buf_off: cover property ($fell(ref_buffer_enable));
endmodule // supply_monitor_sva

bind supply_monitor_and_reference_ctrl supply_monitor_sva chk (.*);

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "supply_monitor_map.vh"

module testbench;
    localparam [31:0] REF_SEQ = 32'h07040300;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         supply_ok = 1'b0;
    wire        hreadyout, hresp, sat, en, trip, v25, v12, buf_on, route, irq_n, irq_f;
    wire [31:0] hrdata;
    wire [4:0]  chan;
    reg  [31:0] rv;
    reg  [7:0]  d;
    integer     mismatches = 0;
    integer     checks_done = 0;
    integer     i;
    always #20 hclk = ~hclk;
    supply_comparator_model cmp (.hclk(hclk), .supply_ok(supply_ok), .supply_above_trip(sat));
    supply_monitor_and_reference_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .supply_above_trip(sat), .monitor_enable_bit(en), .trip_point_select(trip),
        .vref_2v5_connect(v25), .vref_1v2_connect(v12), .ref_buffer_enable(buf_on),
        .adc_route_supply(route), .adc_positive_channel_select(chan),
        .normal_irq_request(irq_n), .fast_irq_request(irq_f));
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task bus(input [31:0] a, input w, input [31:0] wd);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rv = hrdata;
            // Let registered outputs settle before pins are compared
            #1;
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        mismatches = mismatches + 1;
        results;
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(`ADDR_SUPPLY_MON, 1'b0, 32'h0);
        chk("mon reset", 32'h8, rv);
        bus(`ADDR_REF_CTRL, 1'b0, 32'h0);
        chk("ref reset", 32'h1, rv);
        supply_ok <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            d = REF_SEQ[31-8*i -: 8];
            bus(`ADDR_REF_CTRL, 1'b1, {24'h0, d});
            bus(`ADDR_REF_CTRL, 1'b0, 32'h0);
            chk("ref read", {24'h0, d}, rv);
            chk("2v5 pin", d[1], v25);
            chk("1v2 pin", d[0], v12);
            chk("buffers", d != 8'h00, buf_on);
        end
        bus(`ADDR_SUPPLY_MON, 1'b1, 32'h6);
        chk("trip", 1, trip);
        chk("enable", 1, en);
        bus(`ADDR_SUPPLY_MON, 1'b0, 32'h0);
        chk("mon on", 32'hE, rv);
        bus(`ADDR_SUPPLY_MON, 1'b1, 32'h2);
        chk("trip", 0, trip);
        supply_ok <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(`ADDR_SUPPLY_MON, 1'b0, 32'h0);
        chk("mon low", 32'h3, rv);
        chk("irq masked", 0, {irq_n, irq_f});
        bus(`ADDR_INT_ENABLE, 1'b1, 32'h3);
        repeat (2) @(posedge hclk);
        chk("irq level", 3, {irq_n, irq_f});
        bus(`ADDR_SUPPLY_MON, 1'b1, 32'h3);
        repeat (2) @(posedge hclk);
        chk("holdoff", 0, {irq_n, irq_f});
        supply_ok <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(`ADDR_SUPPLY_MON, 1'b1, 32'h2);
        bus(`ADDR_SUPPLY_MON, 1'b0, 32'h0);
        chk("zero write", 32'hB, rv);
        bus(`ADDR_SUPPLY_MON, 1'b1, 32'h3);
        bus(`ADDR_SUPPLY_MON, 1'b0, 32'h0);
        chk("cleared", 32'hA, rv);
        chk("irq clear", 0, {irq_n, irq_f});
        bus(`ADDR_ADC_CHANNEL, 1'b1, 32'h13);
        chk("route", 1, route);
        chk("channel", 32'h13, chan);
        bus(`ADDR_ADC_CHANNEL, 1'b1, 32'h12);
        chk("route", 0, route);
        bus(32'hFFFF0450, 1'b1, 32'hFF);
        bus(32'hFFFF0450, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rv);
        results;
    end
endmodule // testbench
